// [rxeq_consts.svh]
// Register offsets, field positions and reset values of the receiver control bank
`ifndef RXEQ_CONSTS_SVH
`define RXEQ_CONSTS_SVH
`define RXEQ_OFS_BOOST 8'h03
`define RXEQ_OFS_LOWRATE 8'h0d
`define RXEQ_OFS_PWRCFG 8'h13
`define RXEQ_OFS_OVR 8'h2d
`define RXEQ_OFS_APPLIED 8'h52
`define RXEQ_OFS_ROUTE 8'h31
`define RXEQ_RST_BOOST 8'h80
`define RXEQ_RST_LOWRATE 8'h00
`define RXEQ_RST_PWRCFG 8'h90
`define RXEQ_RST_OVR 8'h88
`define RXEQ_RST_ROUTE 8'h00
`define RXEQ_BIT_AUTO_BYP 0
`define RXEQ_BIT_SD0_PD 6
`define RXEQ_BIT_SD1_PD 5
`define RXEQ_BIT_EQ_PD 3
`define RXEQ_BIT_MAN_BYP 1
`define RXEQ_BIT_OVR_EN 3
`define RXEQ_BIT_ROUTE_IN 1
`endif

// [rxeq_host.sv]
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module rxeq_host (
	input wire logic i_clk_sys,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_wdata = 8'h00
);
	// One-cycle strobe; idle lines flip so stale values never match
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		#1;
		{o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
		@(posedge i_clk_sys);
		#1;
		{o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
	endtask
endmodule

// [rxeq_pkg.sv]
// Types shared by the receiver control bank
package rxeq_pkg;
	typedef struct packed {
		logic [7:0] boost;
		logic [7:0] lowrate;
		logic [7:0] pwrcfg;
		logic [7:0] ovr;
		logic [7:0] route;
		logic [7:0] rdata;
		logic rvalid;
	} rxeq_state_t;
	typedef struct packed {
		logic first_detector_powerdown;
		logic second_detector_powerdown;
		logic first_eq_powerdown;
		logic second_eq_powerdown;
		logic eq_bypass;
		logic stages34_bypass;
		logic [7:0] eq_stage_boost_levels_applied;
	} rxeq_ctrl_t;
endpackage

// [rxeq_regs.sv]
// Receiver equalizer and signal-detect control register bank
`timescale 1ns/1ps
`include "rxeq_consts.svh"

module rxeq_regs
	import rxeq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_adapt_valid,
	input wire logic [7:0] i_adapt_boost,
	input wire logic i_rate_lowest,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output rxeq_ctrl_t o_ctrl
);

	//////////////////////////////////////////////////////////////////////
	rxeq_state_t s_q;
	rxeq_state_t s_d;
	rxeq_ctrl_t ctrl_q;
	rxeq_ctrl_t ctrl_d;

	// Read mux shared by the bus path
	function automatic logic [7:0] read_mux(input rxeq_state_t s, input logic [7:0] a,
		input logic [7:0] applied);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			`RXEQ_OFS_BOOST: r = s.boost;
			`RXEQ_OFS_LOWRATE: r = s.lowrate;
			`RXEQ_OFS_PWRCFG: r = s.pwrcfg;
			`RXEQ_OFS_OVR: r = s.ovr;
			`RXEQ_OFS_ROUTE: r = s.route;
			`RXEQ_OFS_APPLIED: r = applied;
			default: r = 8'h00; // Unmapped reads as zero
		endcase
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Register writes, adaptation updates and readback
	always_comb begin
		s_d = s_q;
		s_d.rvalid = i_reg_rd;
		s_d.rdata = read_mux(s_q, i_reg_addr, ctrl_q.eq_stage_boost_levels_applied);
		// Adaptation writes the boost field back; a host boost write in the same cycle wins
		if (i_adapt_valid) begin
			s_d.boost = i_adapt_boost;
		end
		if (i_reg_wr) begin
			// Whole bytes stored, reserved bits included
			unique case (i_reg_addr)
				`RXEQ_OFS_BOOST: s_d.boost = i_reg_wdata;
				`RXEQ_OFS_LOWRATE: s_d.lowrate = i_reg_wdata;
				`RXEQ_OFS_PWRCFG: s_d.pwrcfg = i_reg_wdata;
				`RXEQ_OFS_OVR: s_d.ovr = i_reg_wdata;
				`RXEQ_OFS_ROUTE: s_d.route = i_reg_wdata;
				default: s_d.boost = s_d.boost; // Ignored write
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Analog control decode, registered so outputs come from flops
	always_comb begin
		logic sel_second;
		logic man;
		sel_second = s_q.route[`RXEQ_BIT_ROUTE_IN];
		man = s_q.pwrcfg[`RXEQ_BIT_MAN_BYP];
		ctrl_d.first_detector_powerdown = s_q.pwrcfg[`RXEQ_BIT_SD0_PD];
		ctrl_d.second_detector_powerdown = s_q.pwrcfg[`RXEQ_BIT_SD1_PD];
		// Unselected side forced off regardless of the power-down bit
		ctrl_d.first_eq_powerdown = sel_second | s_q.pwrcfg[`RXEQ_BIT_EQ_PD];
		ctrl_d.second_eq_powerdown = ~sel_second | s_q.pwrcfg[`RXEQ_BIT_EQ_PD];
		ctrl_d.stages34_bypass = man;
		// Manual bypass masks the low-rate automatic one
		ctrl_d.eq_bypass = man | (s_q.lowrate[`RXEQ_BIT_AUTO_BYP] & i_rate_lowest);
		// Override on: the register drives the equalizer at every rate
		ctrl_d.eq_stage_boost_levels_applied = s_q.boost;
		if (!s_q.ovr[`RXEQ_BIT_OVR_EN]) begin
			// Override off: host writes never reach the equalizer
			// Limitation: last applied value holds until adaptation speaks again
			ctrl_d.eq_stage_boost_levels_applied = ctrl_q.eq_stage_boost_levels_applied;
			if (i_adapt_valid) begin
				ctrl_d.eq_stage_boost_levels_applied = i_adapt_boost;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			s_q.boost <= `RXEQ_RST_BOOST;
			s_q.lowrate <= `RXEQ_RST_LOWRATE;
			s_q.pwrcfg <= `RXEQ_RST_PWRCFG;
			s_q.ovr <= `RXEQ_RST_OVR;
			s_q.route <= `RXEQ_RST_ROUTE;
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
			ctrl_q <= '0;
		end else begin
			s_q <= s_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign o_reg_rdata = s_q.rdata;
	assign o_reg_rvalid = s_q.rvalid;
	assign o_ctrl = ctrl_q;

	//////////////////////////////////////////////////////////////////////
	// Checks: reset defaults and register storage
	a_boost_reset: assert property (@(posedge i_clk_sys)
		$past(i_sys_rst) && !i_sys_rst |->
		s_q.boost == `RXEQ_RST_BOOST && s_q.pwrcfg == `RXEQ_RST_PWRCFG &&
		s_q.lowrate == `RXEQ_RST_LOWRATE && s_q.ovr == `RXEQ_RST_OVR &&
		s_q.route == `RXEQ_RST_ROUTE)
		else $error("reset values wrong");
	a_boost_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_BOOST |=> s_q.boost == $past(i_reg_wdata))
		else $error("boost write lost");
	a_lowrate_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_LOWRATE |=> s_q.lowrate == $past(i_reg_wdata))
		else $error("low-rate write lost");
	a_pwrcfg_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_PWRCFG |=> s_q.pwrcfg == $past(i_reg_wdata))
		else $error("power config write lost");
	a_ovr_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_OVR |=> s_q.ovr == $past(i_reg_wdata))
		else $error("override write lost");
	a_route_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_ROUTE |=> s_q.route == $past(i_reg_wdata))
		else $error("route write lost");
	a_adapt_update: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_adapt_valid && !(i_reg_wr && i_reg_addr == `RXEQ_OFS_BOOST) |=>
		s_q.boost == $past(i_adapt_boost))
		else $error("adaptation not stored");
	a_applied_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_wr && i_reg_addr == `RXEQ_OFS_APPLIED && !i_adapt_valid |=>
		s_q.boost == $past(s_q.boost))
		else $error("applied boost written");

	//////////////////////////////////////////////////////////////////////
	// Checks: readback path
	a_applied_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_reg_rd && i_reg_addr == `RXEQ_OFS_APPLIED |=> o_reg_rvalid &&
		o_reg_rdata == $past(o_ctrl.eq_stage_boost_levels_applied))
		else $error("applied boost readback wrong");
	a_read_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=> o_reg_rvalid == $past(i_reg_rd))
		else $error("read valid misplaced");

	//////////////////////////////////////////////////////////////////////
	// Checks: bypass decode
	a_man_bypass: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_q.pwrcfg[`RXEQ_BIT_MAN_BYP] |=> o_ctrl.eq_bypass && o_ctrl.stages34_bypass)
		else $error("manual bypass ignored");
	a_stage_enable: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.pwrcfg[`RXEQ_BIT_MAN_BYP] |=> !o_ctrl.stages34_bypass)
		else $error("stages bypassed without request");
	a_auto_bypass: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.pwrcfg[`RXEQ_BIT_MAN_BYP] && i_rate_lowest |=>
		o_ctrl.eq_bypass == $past(s_q.lowrate[`RXEQ_BIT_AUTO_BYP]))
		else $error("auto bypass wrong");
	a_rate_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.pwrcfg[`RXEQ_BIT_MAN_BYP] && !i_rate_lowest |=> !o_ctrl.eq_bypass)
		else $error("bypass away from lowest rate");
	a_no_bypass: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.pwrcfg[`RXEQ_BIT_MAN_BYP] && !s_q.lowrate[`RXEQ_BIT_AUTO_BYP] |=>
		!o_ctrl.eq_bypass)
		else $error("bypass with both bits clear");

	//////////////////////////////////////////////////////////////////////
	// Checks: power-down decode
	a_det_pd: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		1'b1 |=>
		o_ctrl.first_detector_powerdown == $past(s_q.pwrcfg[`RXEQ_BIT_SD0_PD]) &&
		o_ctrl.second_detector_powerdown == $past(s_q.pwrcfg[`RXEQ_BIT_SD1_PD]))
		else $error("detector powerdown wrong");
	a_unsel_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_q.route[`RXEQ_BIT_ROUTE_IN] |=> o_ctrl.first_eq_powerdown)
		else $error("unselected eq powered");
	a_unsel_second: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.route[`RXEQ_BIT_ROUTE_IN] |=> o_ctrl.second_eq_powerdown)
		else $error("unselected second eq powered");
	a_sel_pd: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.route[`RXEQ_BIT_ROUTE_IN] |=>
		o_ctrl.first_eq_powerdown == $past(s_q.pwrcfg[`RXEQ_BIT_EQ_PD]))
		else $error("selected eq powerdown wrong");
	a_sel_second: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_q.route[`RXEQ_BIT_ROUTE_IN] |=>
		o_ctrl.second_eq_powerdown == $past(s_q.pwrcfg[`RXEQ_BIT_EQ_PD]))
		else $error("selected second eq powerdown wrong");

	//////////////////////////////////////////////////////////////////////
	// Checks: applied boost source
	a_override: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_q.ovr[`RXEQ_BIT_OVR_EN] |=> o_ctrl.eq_stage_boost_levels_applied == $past(s_q.boost))
		else $error("override not applied");
	a_ovr_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.ovr[`RXEQ_BIT_OVR_EN] && !i_adapt_valid |=>
		o_ctrl.eq_stage_boost_levels_applied == $past(o_ctrl.eq_stage_boost_levels_applied))
		else $error("host boost applied without override");
	a_ovr_adapt: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!s_q.ovr[`RXEQ_BIT_OVR_EN] && i_adapt_valid |=>
		o_ctrl.eq_stage_boost_levels_applied == $past(i_adapt_boost))
		else $error("adapted boost not applied");
endmodule

// [rxeq_regs_tb.sv]
// Self-checking bench for the receiver control bank
`timescale 1ns/1ps
module rxeq_regs_tb;
	import rxeq_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr, rd, av = 1'b0, rl = 1'b0, rv, rs = 1'b0;
	logic [7:0] a, wd, ab = 8'h00, rdat, b, pw = 8'h90, lr = 8'h00, ap = 8'h80, bm = 8'h80;
	logic ov = 1'b1;
	logic [31:0] x = 32'h0112;
	logic [7:0] q[$];
	rxeq_ctrl_t ct;
	int err_total = 0, checked = 0, cyc = 0;
	int bt[4] = '{6, 5, 3, 1};
	// 100 ns clock
	always #50 clk = ~clk;
	rxeq_host host (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(a), .o_wdata(wd));
	rxeq_regs dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(a), .i_reg_wdata(wd), .i_adapt_valid(av), .i_adapt_boost(ab),
		.i_rate_lowest(rl), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_ctrl(ct));
	////////////////////////////////////////////////////////////////
	// Xorshift source for boost values
	function logic [7:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x[7:0];
	endfunction
	// Expected control word; unselected equalizer always down
	function logic [13:0] ex();
		return {pw[6], pw[5], pw[3] | rs, pw[3] | !rs, pw[1] | (lr[0] & rl), pw[1], ap};
	endfunction
	task automatic cmp(input logic [13:0] g, input logic [13:0] e, input string m);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: read got %h want %h", $time, g, e);
		end
	endtask
	task test_done();
		// A read that never answered is a mismatch too
		if (q.size() != 0) err_total++;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Write also updates the expected register model
	task w(input logic [7:0] ad, input logic [7:0] d);
		host.acc(1'b1, ad, d);
		if (ad == 8'h03) bm = d;
		if (ad == 8'h13) pw = d;
		if (ad == 8'h0d) lr = d;
		if (ad == 8'h31) rs = d[1];
		if (ad == 8'h2d) ov = d[3];
		// Host boost reaches the equalizer only under override
		if (ov) ap = bm;
	endtask
	task r(input logic [7:0] ad, input logic [7:0] e);
		q.push_back(e);
		host.acc(1'b0, ad, 8'h00);
	endtask
	// Control outputs lag a change by two cycles, so wait three
	task c();
		repeat (3) @(posedge clk);
		#1;
		cmp(ct, ex(), "ctrl");
	endtask
	////////////////////////////////////////////////////////////////
	// Read monitor takes the oldest note at mid-cycle, where outputs are settled
	always @(negedge clk) begin
		if (rv === 1'b1) begin
			if (q.size() == 0) begin
				err_total++;
				$display("CHECK FAILED at %0t: read data with no note", $time);
			end else begin
				cmp_rd(rdat, q.pop_front());
			end
		end
	end
	// Hang limit, far above the length of the sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		r(8'h03, 8'h80);
		r(8'h0d, 8'h00);
		r(8'h13, 8'h90);
		r(8'h2d, 8'h88);
		r(8'h31, 8'h00);
		r(8'h40, 8'h00);
		c();
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			b = rnd();
			w(8'h03, b);
			w(8'h52, ~b);
			r(8'h52, b);
			c();
		end
		$display("boost test done");
		for (int i = 0; i < 4; i++) begin
			w(8'h13, 8'h90 | (8'h01 << bt[i]));
			c();
		end
		w(8'h31, 8'h02);
		c();
		w(8'h13, 8'h98);
		c();
		w(8'h13, 8'h90);
		w(8'h0d, 8'h01);
		rl = 1'b1;
		c();
		w(8'h13, 8'h92);
		c();
		w(8'h13, 8'h90);
		w(8'h0d, 8'h00);
		c();
		$display("power test done");
		w(8'h2d, 8'h80);
		r(8'h2d, 8'h80);
		b = rnd();
		{ab, av, ap, bm} = {b, 1'b1, b, b};
		c();
		av = 1'b0;
		r(8'h03, b);
		// Host write without override is stored but not applied
		w(8'h03, 8'h5a);
		c();
		r(8'h03, 8'h5a);
		w(8'h2d, 8'h88);
		c();
		w(8'h03, 8'h1b);
		c();
		$display("adapt test done");
		// Mid-run reset returns every register to its default
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		{pw, lr, rs, ov, bm, ap} = {8'h90, 8'h00, 1'b0, 1'b1, 8'h80, 8'h80};
		r(8'h13, 8'h90);
		r(8'h2d, 8'h88);
		r(8'h03, 8'h80);
		c();
		$display("second reset test done");
		test_done();
	end
endmodule
